// ==== common/cssd_pkg.sv ====
// Constants, register map and shared helpers of the clock source select and divide block.
// Assumes a 32-bit Wishbone register bus and oscillator ticks synchronous to ref_clk.
package cssd_pkg;

  localparam int REF_CLK_HZ = 50_000_000;
  localparam int MID_OSC_HZ = 8_000_000;
  localparam int WDT_OSC_HZ = 15_000;

  localparam logic [7:0] OFF_MAIN_OSC = 8'h00;
  localparam logic [7:0] OFF_SUB_OSC = 8'h04;
  localparam logic [7:0] OFF_HIGH_OSC = 8'h08;
  localparam logic [7:0] OFF_MID_OSC = 8'h0c;
  localparam logic [7:0] OFF_LOW_OSC = 8'h10;
  localparam logic [7:0] OFF_SRC_SEL = 8'h14;
  localparam logic [7:0] OFF_DIV_CTRL = 8'h18;
  localparam logic [7:0] OFF_PLL = 8'h1c;
  localparam logic [7:0] OFF_PLL_TWO = 8'h20;
  localparam logic [7:0] OFF_SECOND_PLL = 8'h24;
  localparam logic [7:0] OFF_USB_DIV = 8'h28;
  localparam logic [7:0] OFF_MAIN_MODE = 8'h2c;
  localparam logic [7:0] OFF_STATUS = 8'h30;

  localparam int NUM_OSC = 5;
  localparam int OSC_MAIN = 0;
  localparam int OSC_SUB = 1;
  localparam int OSC_HIGH = 2;
  localparam int OSC_MID = 3;
  localparam int OSC_LOW = 4;
  localparam logic [4:0] OSC_RUN_RST = 5'h18;

  typedef enum logic [2:0] {
    SRC_HIGH = 3'h0,
    SRC_MID = 3'h1,
    SRC_LOW = 3'h2,
    SRC_MAIN = 3'h3,
    SRC_SUB = 3'h4,
    SRC_PLL = 3'h5
  } cssd_src_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_HOLD = 2'h1,
    ST_APPLY = 2'h3
  } cssd_sw_state_t;

  localparam int NUM_TREE = 8;
  localparam int DIV_FIELD_W = 4;
  localparam int DIV_CORE = 0;
  localparam int DIV_PA = 1;
  localparam int DIV_PB = 2;
  localparam int DIV_PC = 3;
  localparam int DIV_PD = 4;
  localparam int DIV_FLASH = 5;
  localparam int DIV_BUS = 6;
  localparam int DIV_TRACE = 7;
  localparam logic [31:0] DIV_CTRL_RST = 32'h0000_0000;
  localparam logic [2:0] MAX_DIV_LOG2 = 3'h6;

  localparam int PLL_PREDIV_LSB = 0;
  localparam int PLL_SRC_BIT = 4;
  localparam int PLL_MUL_LSB = 8;
  localparam int PLL_RUN_BIT = 16;
  localparam int PLL_FLL_BIT = 20;
  localparam logic [31:0] PLL_RST = 32'h0000_0000;
  localparam logic [3:0] USB_DIV_RST = 4'h4;

  localparam logic [7:0] SWITCH_HOLD_TICKS = 8'h40;

  localparam int ST_OSC_LSB = 0;
  localparam int ST_PLL_LOCK = 5;
  localparam int ST_SW_BUSY = 6;
  localparam int ST_STRAP_HIGH = 7;
  localparam int ST_WDT_RUN = 8;

  // Byte-lane merge for Wishbone writes.
  function automatic logic [31:0] cssd_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // A log2 ratio code becomes a divide-by-minus-one count; codes above six saturate.
  function automatic logic [7:0] cssd_div_m1(input logic [3:0] code);
    logic [2:0] c;
    c = (code > 4'(MAX_DIV_LOG2)) ? MAX_DIV_LOG2 : code[2:0];
    return 8'((9'h001 << c) - 9'h001);
  endfunction

endpackage

// ==== hdl/cssd_clock_ctrl.sv ====
// Clock source select and divide controller with a Wishbone register file.
// Assumes oscillator and PLL ticks and stable flags arrive synchronous to ref_clk.
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
module cssd_clock_ctrl #(
  parameter bit M33_VARIANT = 1'b1,
  parameter int SWITCH_TIMEOUT_CYC = 4096
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic opt_high_osc_start,
  input wire logic opt_wdt_osc_start,
  input wire logic [4:0] osc_tick_i,
  input wire logic [4:0] osc_stable_i,
  input wire logic pll_tick_i,
  input wire logic pll_lock_i,
  input wire logic second_pll_tick_i,
  input wire logic wdt_osc_tick_i,
  output logic [4:0] osc_run_o,
  output logic main_osc_ext_mode_o,
  output logic main_osc_xtal_drive_o,
  output logic pll_run_o,
  output logic pll_src_high_o,
  output logic [1:0] pll_prediv_o,
  output logic [5:0] pll_mul_o,
  output logic fll_en_o,
  output logic second_pll_run_o,
  output logic [5:0] second_pll_mul_o,
  output logic wdt_osc_run_o,
  output logic wdt_clk_tick_o,
  output logic cac_ref_tick_o,
  output logic system_core_clock_tick_o,
  output logic peripheral_clock_a_tick_o,
  output logic peripheral_clock_b_tick_o,
  output logic peripheral_clock_c_tick_o,
  output logic peripheral_clock_d_tick_o,
  output logic flash_interface_clock_tick_o,
  output logic ext_bus_clock_tick_o,
  output logic trace_clock_tick_o,
  output logic usb_clock_tick_o
);

  initial begin
    if (SWITCH_TIMEOUT_CYC < 1 || SWITCH_TIMEOUT_CYC > 65535) begin
      $error("cssd_clock_ctrl switch timeout out of range");
    end
  end

  localparam logic [15:0] TIMEOUT_LAST = 16'(SWITCH_TIMEOUT_CYC - 1);

  logic ack_ff;
  logic [31:0] dat_ff;
  logic [31:0] rd_data;
  logic init_ff;
  logic wr_en;
  logic [7:0] wr_adr;
  logic [4:0] osc_run_ff;
  logic [4:0] osc_run_rb_ff;
  logic strap_high_ff;
  logic wdt_run_ff;
  logic wdt_tick_ff;
  logic cac_tick_ff;
  logic [2:0] src_req_ff;
  logic [2:0] src_act_ff;
  logic [31:0] div_req_ff;
  logic [31:0] div_act_ff;
  logic [31:0] pll_ff;
  logic [3:0] pll_two_ff;
  logic [31:0] second_pll_ff;
  logic [3:0] usb_div_ff;
  logic ext_mode_ff;
  logic xtal_drive_ff;
  cssd_pkg::cssd_sw_state_t fsm_ff;
  cssd_pkg::cssd_sw_state_t nxt_fsm;
  logic [7:0] hold_cnt_ff;
  logic [15:0] timeout_ff;
  logic sel_tick;
  logic hold_done;
  logic tree_hold;
  logic tree_restart;
  logic [7:0] tree_tick;
  logic usb_src_tick;
  logic [3:0] usb_div_sel;
  logic [2:0] src_wr_val;
  logic [31:0] src_wr_word;

  assign wr_adr = {wb_adr_i[7:2], 2'b00};
  // Writes land at the edge where the master samples ack, and only after the straps are caught.
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && init_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dat_ff <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_ff) begin
      dat_ff <= rd_data;
    end
  end

  // Read-back of switch and oscillator registers shows the applied value.
  always_comb begin
    rd_data = 32'h0000_0000;
    case (wr_adr)
      cssd_pkg::OFF_MAIN_OSC: rd_data = {31'h0, osc_run_rb_ff[cssd_pkg::OSC_MAIN]};
      cssd_pkg::OFF_SUB_OSC: rd_data = {31'h0, osc_run_rb_ff[cssd_pkg::OSC_SUB]};
      cssd_pkg::OFF_HIGH_OSC: rd_data = {31'h0, osc_run_rb_ff[cssd_pkg::OSC_HIGH]};
      cssd_pkg::OFF_MID_OSC: rd_data = {31'h0, osc_run_rb_ff[cssd_pkg::OSC_MID]};
      cssd_pkg::OFF_LOW_OSC: rd_data = {31'h0, osc_run_rb_ff[cssd_pkg::OSC_LOW]};
      cssd_pkg::OFF_SRC_SEL: rd_data = {29'h0, src_act_ff};
      cssd_pkg::OFF_DIV_CTRL: rd_data = div_act_ff;
      cssd_pkg::OFF_PLL: rd_data = pll_ff;
      cssd_pkg::OFF_PLL_TWO: rd_data = {28'h0, pll_two_ff};
      cssd_pkg::OFF_SECOND_PLL: rd_data = second_pll_ff;
      cssd_pkg::OFF_USB_DIV: rd_data = {28'h0, usb_div_ff};
      cssd_pkg::OFF_MAIN_MODE: rd_data = {31'h0, ext_mode_ff};
      cssd_pkg::OFF_STATUS: rd_data = {23'h0, wdt_run_ff, strap_high_ff, fsm_ff != cssd_pkg::ST_RUN,
                                       pll_lock_i, osc_stable_i};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      init_ff <= 1'b0;
    end else begin
      init_ff <= 1'b1;
    end
  end

  // Straps are caught in the first cycle after release, never through the reset itself.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strap_high_ff <= 1'b0;
      wdt_run_ff <= 1'b0;
    end else if (!init_ff) begin
      strap_high_ff <= opt_high_osc_start;
      wdt_run_ff <= opt_wdt_osc_start;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      osc_run_ff <= cssd_pkg::OSC_RUN_RST;
    end else if (!init_ff) begin
      osc_run_ff[cssd_pkg::OSC_HIGH] <= opt_high_osc_start;
    end else if (wr_en && wb_sel_i[0]) begin
      case (wr_adr)
        cssd_pkg::OFF_MAIN_OSC: osc_run_ff[cssd_pkg::OSC_MAIN] <= wb_dat_i[0];
        cssd_pkg::OFF_SUB_OSC: osc_run_ff[cssd_pkg::OSC_SUB] <= wb_dat_i[0];
        cssd_pkg::OFF_HIGH_OSC: osc_run_ff[cssd_pkg::OSC_HIGH] <= wb_dat_i[0];
        cssd_pkg::OFF_MID_OSC: osc_run_ff[cssd_pkg::OSC_MID] <= wb_dat_i[0];
        cssd_pkg::OFF_LOW_OSC: osc_run_ff[cssd_pkg::OSC_LOW] <= wb_dat_i[0];
        default: osc_run_ff <= osc_run_ff;
      endcase
    end
  end

  // An oscillator's read-back follows its request only once its stable flag agrees.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      osc_run_rb_ff <= cssd_pkg::OSC_RUN_RST;
    end else begin
      for (int i = 0; i < cssd_pkg::NUM_OSC; i++) begin
        if (osc_stable_i[i] == osc_run_ff[i]) begin
          osc_run_rb_ff[i] <= osc_run_ff[i];
        end
      end
    end
  end

  assign osc_run_o = osc_run_ff;

  // The watchdog oscillator reaches only the watchdog and the accuracy reference.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wdt_tick_ff <= 1'b0;
      cac_tick_ff <= 1'b0;
    end else begin
      wdt_tick_ff <= wdt_osc_tick_i && wdt_run_ff;
      cac_tick_ff <= wdt_osc_tick_i && wdt_run_ff;
    end
  end

  assign wdt_osc_run_o = wdt_run_ff;
  assign wdt_clk_tick_o = wdt_tick_ff;
  assign cac_ref_tick_o = cac_tick_ff;

  assign src_wr_word = cssd_pkg::cssd_merge({29'h0, src_req_ff}, wb_dat_i, wb_sel_i);
  assign src_wr_val = src_wr_word[2:0];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      src_req_ff <= cssd_pkg::SRC_MID;
      div_req_ff <= cssd_pkg::DIV_CTRL_RST;
    end else if (wr_en) begin
      // Codes beyond the PLL are not sources, and the watchdog oscillator has none.
      if (wr_adr == cssd_pkg::OFF_SRC_SEL && src_wr_val <= cssd_pkg::SRC_PLL) begin
        src_req_ff <= src_wr_val;
      end
      if (wr_adr == cssd_pkg::OFF_DIV_CTRL) begin
        div_req_ff <= cssd_pkg::cssd_merge(div_req_ff, wb_dat_i, wb_sel_i);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pll_ff <= cssd_pkg::PLL_RST;
      pll_two_ff <= cssd_pkg::USB_DIV_RST;
      second_pll_ff <= cssd_pkg::PLL_RST;
      usb_div_ff <= cssd_pkg::USB_DIV_RST;
      ext_mode_ff <= 1'b0;
    end else if (wr_en) begin
      case (wr_adr)
        cssd_pkg::OFF_PLL: pll_ff <= cssd_pkg::cssd_merge(pll_ff, wb_dat_i, wb_sel_i);
        cssd_pkg::OFF_PLL_TWO: pll_two_ff <= wb_sel_i[0] ? wb_dat_i[3:0] : pll_two_ff;
        cssd_pkg::OFF_SECOND_PLL: second_pll_ff <= cssd_pkg::cssd_merge(second_pll_ff, wb_dat_i, wb_sel_i);
        cssd_pkg::OFF_USB_DIV: usb_div_ff <= wb_sel_i[0] ? wb_dat_i[3:0] : usb_div_ff;
        cssd_pkg::OFF_MAIN_MODE: ext_mode_ff <= wb_sel_i[0] ? wb_dat_i[0] : ext_mode_ff;
        default: pll_ff <= pll_ff;
      endcase
    end
  end

  // In external clock mode the crystal output is left undriven.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      xtal_drive_ff <= 1'b0;
    end else begin
      xtal_drive_ff <= !ext_mode_ff && osc_run_ff[cssd_pkg::OSC_MAIN];
    end
  end

  assign main_osc_ext_mode_o = ext_mode_ff;
  assign main_osc_xtal_drive_o = xtal_drive_ff;
  assign pll_run_o = pll_ff[cssd_pkg::PLL_RUN_BIT];
  assign pll_src_high_o = pll_ff[cssd_pkg::PLL_SRC_BIT];
  assign pll_prediv_o = pll_ff[cssd_pkg::PLL_PREDIV_LSB +: 2];
  assign pll_mul_o = pll_ff[cssd_pkg::PLL_MUL_LSB +: 6];
  assign fll_en_o = pll_ff[cssd_pkg::PLL_FLL_BIT];
  assign second_pll_run_o = second_pll_ff[cssd_pkg::PLL_RUN_BIT];
  assign second_pll_mul_o = second_pll_ff[cssd_pkg::PLL_MUL_LSB +: 6];

  // A stopped source yields no ticks, so selecting it freezes the tree rather than glitching.
  always_comb begin
    sel_tick = 1'b0;
    case (src_act_ff)
      cssd_pkg::SRC_HIGH: sel_tick = osc_tick_i[cssd_pkg::OSC_HIGH] && osc_run_ff[cssd_pkg::OSC_HIGH];
      cssd_pkg::SRC_MID: sel_tick = osc_tick_i[cssd_pkg::OSC_MID] && osc_run_ff[cssd_pkg::OSC_MID];
      cssd_pkg::SRC_LOW: sel_tick = osc_tick_i[cssd_pkg::OSC_LOW] && osc_run_ff[cssd_pkg::OSC_LOW];
      cssd_pkg::SRC_MAIN: sel_tick = osc_tick_i[cssd_pkg::OSC_MAIN] && osc_run_ff[cssd_pkg::OSC_MAIN];
      cssd_pkg::SRC_SUB: sel_tick = osc_tick_i[cssd_pkg::OSC_SUB] && osc_run_ff[cssd_pkg::OSC_SUB];
      cssd_pkg::SRC_PLL: sel_tick = pll_tick_i && pll_ff[cssd_pkg::PLL_RUN_BIT];
      default: sel_tick = 1'b0;
    endcase
  end

  // Tree outputs are held silent until the old source runs a full longest ratio or the switch timeout ends, then the new
  // source starts every tree divider from zero: each gap spans at least the new period, and the old one unless timed out.
  assign hold_done = (sel_tick && hold_cnt_ff == 8'(cssd_pkg::SWITCH_HOLD_TICKS - 8'h01)) ||
                     (timeout_ff == TIMEOUT_LAST);
  assign tree_hold = fsm_ff != cssd_pkg::ST_RUN;
  assign tree_restart = fsm_ff == cssd_pkg::ST_APPLY;

  always_comb begin
    nxt_fsm = fsm_ff;
    case (fsm_ff)
      cssd_pkg::ST_RUN: begin
        if (src_req_ff != src_act_ff || div_req_ff != div_act_ff) begin
          nxt_fsm = cssd_pkg::ST_HOLD;
        end
      end
      cssd_pkg::ST_HOLD: begin
        if (hold_done) begin
          nxt_fsm = cssd_pkg::ST_APPLY;
        end
      end
      cssd_pkg::ST_APPLY: nxt_fsm = cssd_pkg::ST_RUN;
      default: nxt_fsm = cssd_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fsm_ff <= cssd_pkg::ST_RUN;
      hold_cnt_ff <= 8'h00;
      timeout_ff <= 16'h0000;
    end else begin
      fsm_ff <= nxt_fsm;
      if (fsm_ff != cssd_pkg::ST_HOLD) begin
        hold_cnt_ff <= 8'h00;
        timeout_ff <= 16'h0000;
      end else begin
        hold_cnt_ff <= sel_tick ? 8'(hold_cnt_ff + 8'h01) : hold_cnt_ff;
        timeout_ff <= 16'(timeout_ff + 16'h0001);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      src_act_ff <= cssd_pkg::SRC_MID;
      div_act_ff <= cssd_pkg::DIV_CTRL_RST;
    end else if (fsm_ff == cssd_pkg::ST_HOLD && hold_done) begin
      src_act_ff <= src_req_ff;
      div_act_ff <= div_req_ff;
    end
  end

  for (genvar g = 0; g < cssd_pkg::NUM_TREE; g++) begin : g_tree
    cssd_divider #(
      .W(8)
    ) u_div (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .src_tick(sel_tick),
      .restart(tree_restart),
      .hold(tree_hold),
      .div_m1(cssd_pkg::cssd_div_m1(div_act_ff[cssd_pkg::DIV_FIELD_W*g +: cssd_pkg::DIV_FIELD_W])),
      .tick_o(tree_tick[g])
    );
  end

  // The core tick also clocks the CPU, DMA, flash access and SDRAM.
  assign system_core_clock_tick_o = tree_tick[cssd_pkg::DIV_CORE];
  assign peripheral_clock_a_tick_o = tree_tick[cssd_pkg::DIV_PA];
  assign peripheral_clock_b_tick_o = tree_tick[cssd_pkg::DIV_PB];
  assign peripheral_clock_c_tick_o = tree_tick[cssd_pkg::DIV_PC];
  assign peripheral_clock_d_tick_o = tree_tick[cssd_pkg::DIV_PD];
  // Flash program, erase and data flash reads run on this tick, code reads do not.
  assign flash_interface_clock_tick_o = tree_tick[cssd_pkg::DIV_FLASH];
  assign ext_bus_clock_tick_o = tree_tick[cssd_pkg::DIV_BUS];
  assign trace_clock_tick_o = tree_tick[cssd_pkg::DIV_TRACE];

  assign usb_src_tick = (M33_VARIANT && second_pll_ff[cssd_pkg::PLL_RUN_BIT]) ? second_pll_tick_i :
                        (pll_tick_i && pll_ff[cssd_pkg::PLL_RUN_BIT]);
  assign usb_div_sel = M33_VARIANT ? usb_div_ff : pll_two_ff;

  cssd_divider #(
    .W(8)
  ) u_usb_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .src_tick(usb_src_tick),
    .restart(1'b0),
    .hold(1'b0),
    .div_m1({4'h0, usb_div_sel}),
    .tick_o(usb_clock_tick_o)
  );

  reset_mid_src_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(rst_n) |-> src_act_ff == cssd_pkg::SRC_MID && osc_run_o[cssd_pkg::OSC_MID])
    else $error("system source is not the mid-speed oscillator after reset");

  reset_stopped_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(rst_n) |-> !osc_run_o[cssd_pkg::OSC_MAIN] && !pll_run_o)
    else $error("main oscillator or PLL running after reset");

  strap_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !init_ff |=> osc_run_o[cssd_pkg::OSC_HIGH] == $past(opt_high_osc_start) &&
                 wdt_osc_run_o == $past(opt_wdt_osc_start))
    else $error("option straps not applied after reset");

  wdt_relay_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wdt_clk_tick_o |-> $past(wdt_osc_tick_i) && $past(wdt_run_ff) && cac_ref_tick_o)
    else $error("watchdog tick without a running watchdog oscillator");

  osc_readback_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(osc_run_rb_ff) |-> ($past(osc_stable_i) & ($past(osc_run_rb_ff) ^ osc_run_rb_ff)) ==
                                (osc_run_rb_ff & ($past(osc_run_rb_ff) ^ osc_run_rb_ff)))
    else $error("oscillator read-back changed before the oscillator settled");

  switch_silent_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fsm_ff != cssd_pkg::ST_RUN |=> tree_tick == 8'h00)
    else $error("tree clock ticked during a source switch");

  pending_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (fsm_ff == cssd_pkg::ST_RUN && src_req_ff != src_act_ff) |=> fsm_ff == cssd_pkg::ST_HOLD)
    else $error("pending source switch did not start the hold");

  apply_readback_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(src_act_ff) |-> $past(fsm_ff) == cssd_pkg::ST_HOLD && fsm_ff == cssd_pkg::ST_APPLY)
    else $error("applied source changed outside the switch sequence");

  xtal_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    main_osc_ext_mode_o && $past(main_osc_ext_mode_o) |-> !main_osc_xtal_drive_o)
    else $error("crystal output driven in external clock mode");

endmodule

// ==== hdl/cssd_divider.sv ====
// Tick divider: emits one output tick per div_m1+1 source ticks.
// Assumes source ticks are one-cycle pulses synchronous to ref_clk.
`timescale 1ns/10ps
module cssd_divider #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic src_tick,
  input wire logic restart,
  input wire logic hold,
  input wire logic [W-1:0] div_m1,
  output logic tick_o
);

  initial begin
    if (W < 1 || W > 16) begin
      $error("cssd_divider width out of range");
    end
  end

  logic [W-1:0] cnt_ff;
  logic tick_ff;
  logic wrap;

  assign wrap = src_tick && (cnt_ff >= div_m1);
  assign tick_o = tick_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_n || restart) begin
      cnt_ff <= '0;
    end else if (src_tick) begin
      cnt_ff <= wrap ? '0 : W'(cnt_ff + 1'b1);
    end
  end

  // Held ticks are swallowed, so a held output only ever shows longer periods.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= wrap && !hold && !restart;
    end
  end

endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the clock source select and divide controller.
// Assumes the bench itself plays software on Wishbone and all oscillator ticks.
`timescale 1ns/10ps
module tb_top;
  logic ref_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, q;
  logic [4:0] otick = 5'h00, ostab = 5'h00;
  logic [2:0] cnt = 3'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, wdt_osc_run_o, wdt_clk_tick_o, cac_ref_tick_o, core_t, pll_run_o;
  logic main_osc_ext_mode_o, main_osc_xtal_drive_o, usb_t, frequency_locked_loop;
  logic [5:0] pmul;
  logic [4:0] osc_run_o;
  int error_cnt = 0, checks = 0, cyc_cnt = 0;
  always #10 ref_clk = ~ref_clk;
  // Modelled oscillators settle one cycle after their run request changes.
  always @(posedge ref_clk) begin
    cnt <= cnt + 3'h1;
    otick <= {5{cnt[0]}};
    ostab <= osc_run_o;
  end
  cssd_clock_ctrl #(.SWITCH_TIMEOUT_CYC(200)) dut (.ref_clk, .rst_n, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o,
    .wb_ack_o, .opt_high_osc_start(1'b1), .opt_wdt_osc_start(1'b1), .osc_tick_i(otick),
    .osc_stable_i(ostab), .pll_tick_i(cnt[0]), .pll_lock_i(pll_run_o),
    .second_pll_tick_i(cnt[1]), .wdt_osc_tick_i(cnt == 3'h0), .osc_run_o,
    .main_osc_ext_mode_o, .main_osc_xtal_drive_o, .pll_run_o, .pll_src_high_o(),
    .pll_prediv_o(), .pll_mul_o(pmul), .fll_en_o(frequency_locked_loop), .second_pll_run_o(), .second_pll_mul_o(),
    .wdt_osc_run_o, .wdt_clk_tick_o, .cac_ref_tick_o, .system_core_clock_tick_o(core_t),
    .peripheral_clock_a_tick_o(), .peripheral_clock_b_tick_o(), .peripheral_clock_c_tick_o(),
    .peripheral_clock_d_tick_o(), .flash_interface_clock_tick_o(), .ext_bus_clock_tick_o(),
    .trace_clock_tick_o(), .usb_clock_tick_o(usb_t));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      $display("unexpected %0t %s", $time, m);
      error_cnt++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1 && ++n < 50);
    if (n >= 50) begin
      $display("unexpected %0t bus ack timeout", $time);
      error_cnt++;
    end
    q = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do wb(1'b0, cssd_pkg::OFF_STATUS, 32'h0000_0000); while (q[6] !== 1'b0 && ++n < 100);
    if (n >= 100) begin
      $display("unexpected %0t switch never finished", $time);
      error_cnt++;
    end
  endtask
  task automatic count_core(input int cycles, output int k);
    k = 0;
    repeat (cycles) begin
      @(posedge ref_clk);
      if (core_t === 1'b1) k++;
    end
  endtask
  task automatic t_reset();
    chk(32'(osc_run_o), 32'h0000_001c, "osc run at reset");
    chk(32'(pll_run_o), 32'h0000_0000, "pll run at reset");
    wb(1'b0, cssd_pkg::OFF_SRC_SEL, 32'h0000_0000);
    chk(q, 32'h0000_0001, "reset source");
    wb(1'b0, cssd_pkg::OFF_USB_DIV, 32'h0000_0000);
    chk(q, 32'h0000_0004, "usb div reset");
    wb(1'b0, 8'h3c, 32'h0000_0000);
    chk(q, 32'h0000_0000, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_osc();
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 8'(4 * i), 32'h0000_0001);
      repeat (3) @(posedge ref_clk);
      wb(1'b0, 8'(4 * i), 32'h0000_0000);
      chk(q, 32'h0000_0001, "osc start readback");
      chk(32'(osc_run_o[i]), 32'h0000_0001, "osc run pin");
    end
    wb(1'b1, cssd_pkg::OFF_MAIN_MODE, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    chk(32'({main_osc_ext_mode_o, main_osc_xtal_drive_o}), 32'h0000_0002, "ext clk");
    $display("test osc done");
  endtask
  task automatic t_switch();
    int k;
    wb(1'b1, cssd_pkg::OFF_DIV_CTRL, 32'h6000_0002);
    wait_idle();
    wb(1'b1, cssd_pkg::OFF_SRC_SEL, 32'h0000_0000);
    wb(1'b0, cssd_pkg::OFF_SRC_SEL, 32'h0000_0000);
    chk(q, 32'h0000_0001, "source applied early");
    count_core(100, k);
    chk(32'(k), 32'h0000_0000, "tick during switch");
    wait_idle();
    wb(1'b0, cssd_pkg::OFF_SRC_SEL, 32'h0000_0000);
    chk(q, 32'h0000_0000, "source after switch");
    count_core(80, k);
    chk(32'(k), 32'h0000_000a, "core divide by 4");
    wb(1'b1, cssd_pkg::OFF_SRC_SEL, 32'h0000_0006);
    wait_idle();
    wb(1'b0, cssd_pkg::OFF_SRC_SEL, 32'h0000_0000);
    chk(q, 32'h0000_0000, "bad source kept");
    $display("test switch done");
  endtask
  task automatic t_pll();
    int k;
    wb(1'b1, cssd_pkg::OFF_PLL, 32'h0011_1900);
    wb(1'b0, cssd_pkg::OFF_PLL, 32'h0000_0000);
    chk(q, 32'h0011_1900, "pll readback");
    chk(32'({pll_run_o, frequency_locked_loop, pmul}), 32'h0000_00d9, "pll pins");
    k = 0;
    repeat (100) begin
      @(posedge ref_clk);
      if (usb_t === 1'b1) k++;
    end
    chk(32'(k), 32'h0000_000a, "usb divide by 5");
    $display("test pll done");
  endtask
  task automatic t_wdt();
    int k;
    k = 0;
    repeat (80) begin
      @(posedge ref_clk);
      if (wdt_clk_tick_o === 1'b1 && cac_ref_tick_o === 1'b1) k++;
    end
    chk(32'(k), 32'h0000_000a, "watchdog ticks");
    $display("test wdt done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_osc();
    t_switch();
    t_pll();
    t_wdt();
    tally_and_finish();
  end
endmodule
